// [core/remote_i2c_target_id_map.sv]
`timescale 1ns/1ps
`default_nettype none
`include "remote_i2c_target_id_map_map.svh"

module remote_i2c_target_id_map #(
  parameter int unsigned NUM_PORTS = 2
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        ce,
  // Local register access from the I2C target logic
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  // Control channel address delivery per port
  input  wire logic [NUM_PORTS-1:0]        rx_lock,
  input  wire logic [NUM_PORTS-1:0]        bcc_load,
  input  wire logic [NUM_PORTS-1:0][6:0]   bcc_addr,
  // Incoming I2C address to translate
  input  wire logic                        xlate_req,
  input  wire logic [6:0]                  xlate_addr,
  output logic                             fwd_valid,
  output logic                             fwd_miss,
  output logic                             fwd_port,
  output logic                             fwd_is_bridge,
  output logic      [6:0]                  fwd_addr,
  // Per-port settings seen by the rest of the device
  output logic      [NUM_PORTS-1:0][6:0]   remote_bridge_addr,
  output logic      [NUM_PORTS-1:0]        hold_remote_addr,
  output logic      [NUM_PORTS-1:0][6:0]   remote_target_phys_addr,
  output logic      [NUM_PORTS-1:0][6:0]   remote_target_alias,
  output logic                             second_port_select
);

  // ========================================================================
  // Reset release
  logic rst_q1;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ========================================================================
  // Address decode
  wire logic hit_bridge = reg_addr == `OFF_REMOTE_BRIDGE_ADDRESS;
  wire logic hit_phys   = reg_addr == `OFF_REMOTE_TARGET_PHYSICAL_ADDRESS;
  wire logic hit_alias  = reg_addr == `OFF_REMOTE_TARGET_ALIAS_ADDRESS;
  wire logic hit_sel    = reg_addr == `OFF_PORT_SELECT;
  wire logic sel_idx    = second_port_select;
  wire remote_i2c_target_id_map_pkg::i2c_addr_t wr_field =
    reg_wdata[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];

  logic [NUM_PORTS-1:0] phys_spare;
  logic [NUM_PORTS-1:0] wr_bridge;
  logic [NUM_PORTS-1:0] wr_phys;
  logic [NUM_PORTS-1:0] wr_alias;
  logic [NUM_PORTS-1:0] load_ok;
  logic [NUM_PORTS-1:0] bridge_hit;
  logic [NUM_PORTS-1:0] alias_hit;

  // ========================================================================
  // Port select register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      second_port_select <= `RST_BIT;
    else if (ce && reg_wr && hit_sel)
      second_port_select <= reg_wdata[`SECOND_PORT_SEL_BIT];
  end

  // ========================================================================
  // Per-port register copies
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    // Writes steer to the selected copy only
    assign wr_bridge[p] = reg_wr && hit_bridge &&
                          (sel_idx == 1'(p));
    assign wr_phys[p]   = reg_wr && hit_phys &&
                          (sel_idx == 1'(p));
    assign wr_alias[p]  = reg_wr && hit_alias &&
                          (sel_idx == 1'(p));
    assign load_ok[p]   = bcc_load[p] && rx_lock[p] &&
                          !hold_remote_addr[p];
    // Incoming address match, zero values never match
    assign bridge_hit[p] =
      (remote_bridge_addr[p] != `RST_ADDR7) &&
      (xlate_addr == remote_bridge_addr[p]);
    assign alias_hit[p]  =
      (remote_target_alias[p] != `RST_ADDR7) &&
      (xlate_addr == remote_target_alias[p]);

    // Bridge address and hold bit; software write beats auto-load
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        remote_bridge_addr[p] <= `RST_ADDR7;
        hold_remote_addr[p]   <= `RST_BIT;
      end
      else if (ce && wr_bridge[p])
      begin
        remote_bridge_addr[p] <= wr_field;
        hold_remote_addr[p]   <= reg_wdata[`HOLD_BIT];
      end
      else if (ce && load_ok[p])
        remote_bridge_addr[p] <= bcc_addr[p];
    end

    // Physical target address and its spare bit
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        remote_target_phys_addr[p] <= `RST_ADDR7;
        phys_spare[p]              <= `RST_BIT;
      end
      else if (ce && wr_phys[p])
      begin
        remote_target_phys_addr[p] <= wr_field;
        phys_spare[p]              <= reg_wdata[`PHYS_SPARE_BIT];
      end
    end

    // Alias of the remote target
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        remote_target_alias[p] <= `RST_ADDR7;
      else if (ce && wr_alias[p])
        remote_target_alias[p] <= wr_field;
    end
  end

  // ========================================================================
  // Read path
  wire remote_i2c_target_id_map_pkg::reg_byte_t rd_bridge =
    {remote_bridge_addr[sel_idx], hold_remote_addr[sel_idx]};
  wire remote_i2c_target_id_map_pkg::reg_byte_t rd_phys =
    {remote_target_phys_addr[sel_idx], phys_spare[sel_idx]};
  wire remote_i2c_target_id_map_pkg::reg_byte_t rd_alias =
    {remote_target_alias[sel_idx], 1'b0};
  wire remote_i2c_target_id_map_pkg::reg_byte_t rd_sel =
    {7'h00, second_port_select};
  wire remote_i2c_target_id_map_pkg::reg_byte_t next_reg_rdata =
    hit_bridge ? rd_bridge :
    hit_phys   ? rd_phys   :
    hit_alias  ? rd_alias  :
    hit_sel    ? rd_sel    : `RST_RDATA;

  // Read data captured one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `RST_RDATA;
    else if (ce && reg_rd)
      reg_rdata <= next_reg_rdata;
  end

  // ========================================================================
  // Address translation: port 0 first, bridge before target
  wire logic hit_any    = |{bridge_hit, alias_hit};
  wire logic next_port  = !(bridge_hit[0] || alias_hit[0]);
  wire logic next_is_br = bridge_hit[next_port];
  wire remote_i2c_target_id_map_pkg::i2c_addr_t next_fwd_addr =
    next_is_br ? remote_bridge_addr[next_port]
               : remote_target_phys_addr[next_port];

  // Forward result, one cycle pulse per request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fwd_valid     <= 1'b0;
      fwd_miss      <= 1'b0;
      fwd_port      <= 1'b0;
      fwd_is_bridge <= 1'b0;
      fwd_addr      <= `RST_ADDR7;
    end
    else if (ce)
    begin
      fwd_valid <= xlate_req && hit_any;
      fwd_miss  <= xlate_req && !hit_any;
      if (xlate_req && hit_any)
      begin
        fwd_port      <= next_port;
        fwd_is_bridge <= next_is_br;
        fwd_addr      <= next_fwd_addr;
      end
    end
  end

  // ========================================================================
  // Checks
  property p_held_stays;
    @(posedge clk) disable iff (!rst_n)
      hold_remote_addr[0] && !(ce && wr_bridge[0]) |=>
        $stable(remote_bridge_addr[0]);
  endproperty
  a_held_stays: assert property (p_held_stays)
    else $error("held bridge address changed");

  property p_autoload;
    @(posedge clk) disable iff (!rst_n)
      ce && bcc_load[1] && rx_lock[1] && !hold_remote_addr[1] &&
      !wr_bridge[1] |=> remote_bridge_addr[1] == $past(bcc_addr[1]);
  endproperty
  a_autoload: assert property (p_autoload)
    else $error("bridge address not loaded after lock");

  property p_no_zero_bridge;
    @(posedge clk) disable iff (!rst_n)
      fwd_valid && fwd_is_bridge |-> fwd_addr != 7'h00;
  endproperty
  a_no_zero_bridge: assert property (p_no_zero_bridge)
    else $error("zero bridge address forwarded");

  property p_alias_remap;
    @(posedge clk) disable iff (!rst_n)
      ce && xlate_req && alias_hit[0] && !bridge_hit[0] |=>
        fwd_valid && !fwd_port && !fwd_is_bridge &&
        fwd_addr == $past(remote_target_phys_addr[0]);
  endproperty
  a_alias_remap: assert property (p_alias_remap)
    else $error("alias not remapped to physical address");

  property p_phys_port1;
    @(posedge clk) disable iff (!rst_n)
      ce && reg_wr && hit_phys && second_port_select |=>
        remote_target_phys_addr[1] == $past(reg_wdata[7:1]) &&
        $stable(remote_target_phys_addr[0]);
  endproperty
  a_phys_port1: assert property (p_phys_port1)
    else $error("physical address write missed port 1");

  property p_bridge_port0;
    @(posedge clk) disable iff (!rst_n)
      ce && reg_wr && hit_bridge && !second_port_select |=>
        remote_bridge_addr[0] == $past(reg_wdata[7:1]) &&
        $stable(remote_bridge_addr[1]) && $stable(hold_remote_addr[1]);
  endproperty
  a_bridge_port0: assert property (p_bridge_port0)
    else $error("bridge write leaked to port 1");

  property p_hold_port1;
    @(posedge clk) disable iff (!rst_n)
      ce && reg_wr && hit_bridge && second_port_select |=>
        hold_remote_addr[1] == $past(reg_wdata[0]);
  endproperty
  a_hold_port1: assert property (p_hold_port1)
    else $error("hold bit write missed port 1");

  property p_read_sel;
    @(posedge clk) disable iff (!rst_n)
      ce && reg_rd && hit_alias |=>
        reg_rdata == {$past(remote_target_alias[second_port_select]), 1'b0};
  endproperty
  a_read_sel: assert property (p_read_sel)
    else $error("read did not return selected copy");

  property p_miss;
    @(posedge clk) disable iff (!rst_n)
      ce && xlate_req && !hit_any |=> fwd_miss && !fwd_valid;
  endproperty
  a_miss: assert property (p_miss)
    else $error("unmatched address not reported as miss");

  property p_zero_addr_miss;
    @(posedge clk) disable iff (!rst_n)
      ce && xlate_req && xlate_addr == 7'h00 |=> fwd_miss && !fwd_valid;
  endproperty
  a_zero_addr_miss: assert property (p_zero_addr_miss)
    else $error("zero address was forwarded");

  property p_phys_port0;
    @(posedge clk) disable iff (!rst_n)
      ce && reg_wr && hit_phys && !second_port_select |=>
        remote_target_phys_addr[0] == $past(reg_wdata[7:1]) &&
        $stable(remote_target_phys_addr[1]);
  endproperty
  a_phys_port0: assert property (p_phys_port0)
    else $error("physical address write leaked to port 1");

  property p_alias_port1;
    @(posedge clk) disable iff (!rst_n)
      ce && reg_wr && hit_alias && second_port_select |=>
        remote_target_alias[1] == $past(reg_wdata[7:1]) &&
        $stable(remote_target_alias[0]);
  endproperty
  a_alias_port1: assert property (p_alias_port1)
    else $error("alias write missed port 1");

endmodule
`default_nettype wire

// [core/remote_i2c_target_id_map_map.svh]
`ifndef REMOTE_I2C_TARGET_ID_MAP_MAP_SVH
`define REMOTE_I2C_TARGET_ID_MAP_MAP_SVH

// ==========================================================================
// Register offsets
`define OFF_REMOTE_BRIDGE_ADDRESS          8'h06
`define OFF_REMOTE_TARGET_PHYSICAL_ADDRESS 8'h07
`define OFF_REMOTE_TARGET_ALIAS_ADDRESS    8'h08
`define OFF_PORT_SELECT                    8'h1e

// ==========================================================================
// Field positions
`define ADDR_FIELD_MSB       7
`define ADDR_FIELD_LSB       1
`define HOLD_BIT             0
`define PHYS_SPARE_BIT       0
`define SECOND_PORT_SEL_BIT  0

// ==========================================================================
// Reset values
`define RST_ADDR7            7'h00
`define RST_BIT              1'b0
`define RST_RDATA            8'h00

`endif

// [core/remote_i2c_target_id_map_pkg.sv]
// ==========================================================================
// Shared types
package remote_i2c_target_id_map_pkg;
  typedef logic [6:0] i2c_addr_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// [tb/bcc_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ==================
// Control channel far end: lock levels and address deliveries
module bcc_partner (
  input  wire logic            clk,
  input  wire logic [1:0]      lock_req,
  output logic      [1:0]      rx_lock,
  output logic      [1:0]      bcc_load,
  output logic      [1:0][6:0] bcc_addr
);
  logic [1:0]      req = 2'h0;
  logic [1:0][6:0] req_addr;
  initial {rx_lock, bcc_load, bcc_addr} = '0;
  // One-cycle delivery pulse; idle address scrambles every cycle
  always @(posedge clk)
  begin
    #1;
    rx_lock = lock_req;
    for (int p = 0; p < 2; p++)
    begin
      bcc_load[p] = req[p];
      bcc_addr[p] = req[p] ? req_addr[p] : ~bcc_addr[p];
    end
    req = 2'h0;
  end
  // Delivery after a prompt or slow wait
  task automatic deliver(input logic p, input logic [6:0] a, input int w);
    repeat (w) @(posedge clk);
    #3;
    req[p] = 1'b1;
    req_addr[p] = a;
    @(posedge clk);
    #2;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            ce = 1'b1;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [7:0]      reg_addr = 8'h00;
  logic [7:0]      reg_wdata = 8'h00;
  logic [7:0]      reg_rdata;
  logic [1:0]      lock_req = 2'h0;
  logic [1:0]      rx_lock, bcc_load, hold;
  logic [1:0][6:0] bcc_addr, rb_addr, phys, alias_a;
  logic            xlate_req = 1'b0;
  logic [6:0]      xlate_addr = 7'h00;
  logic            fwd_valid, fwd_miss, fwd_port, fwd_is_bridge, sel;
  logic [6:0]      fwd_addr;
  logic [6:0]      mb [2], ma [2];
  logic [7:0]      mp [2];
  logic            mh [2];
  logic            msel;
  logic [7:0]      offs [5] = '{8'h06, 8'h07, 8'h08, 8'h1e, 8'h55};
  int              mismatches = 0;
  int              checks_done = 0;
  always #2.5 clk = ~clk;
  remote_i2c_target_id_map dut_u (.clk(clk), .reset_n(reset_n), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_lock(rx_lock),
    .bcc_load(bcc_load), .bcc_addr(bcc_addr), .xlate_req(xlate_req),
    .xlate_addr(xlate_addr), .fwd_valid(fwd_valid), .fwd_miss(fwd_miss),
    .fwd_port(fwd_port), .fwd_is_bridge(fwd_is_bridge), .fwd_addr(fwd_addr),
    .remote_bridge_addr(rb_addr), .hold_remote_addr(hold),
    .remote_target_phys_addr(phys), .remote_target_alias(alias_a),
    .second_port_select(sel));
  bcc_partner bcc_u (.clk(clk), .lock_req(lock_req), .rx_lock(rx_lock),
    .bcc_load(bcc_load), .bcc_addr(bcc_addr));
  // ==================
  // Reference model
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h06: return {mb[msel], mh[msel]};
      8'h07: return mp[msel];
      8'h08: return {ma[msel], 1'b0};
      8'h1e: return {7'h00, msel};
      default: return 8'h00;
    endcase
  endfunction
  function automatic void upd(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h06: {mb[msel], mh[msel]} = d;
      8'h07: mp[msel] = d;
      8'h08: ma[msel] = d[7:1];
      8'h1e: msel = d[0];
      default: ;
    endcase
  endfunction
  // Hit flag, port, bridge flag, address in priority order
  function automatic logic [9:0] exp_xl(input logic [6:0] a);
    for (int p = 0; p < 2; p++)
    begin
      if (mb[p] != 7'h00 && mb[p] == a)
        return {1'b1, p[0], 1'b1, mb[p]};
      if (ma[p] != 7'h00 && ma[p] == a)
        return {1'b1, p[0], 1'b0, mp[p][7:1]};
    end
    return 10'h000;
  endfunction
  // ==================
  // Drivers and comparisons
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmp_all();
    for (int p = 0; p < 2; p++)
    begin
      check({2'h0, rb_addr[p], hold[p]},
            {2'h0, mb[p], mh[p]});
      check({3'h0, phys[p]}, {3'h0, mp[p][7:1]});
      check({3'h0, alias_a[p]}, {3'h0, ma[p]});
    end
    check({9'h000, sel}, {9'h000, msel});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic en);
    @(posedge clk);
    #1;
    {ce, reg_wr, reg_addr, reg_wdata} = {en, 1'b1, a, d};
    @(posedge clk);
    #1;
    {ce, reg_wr} = 2'b10;
    if (en)
      upd(a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    check({2'h0, reg_rdata}, {2'h0, exp_rd(a)});
  endtask
  task automatic xl(input logic [6:0] a);
    logic [9:0] e;
    e = exp_xl(a);
    @(posedge clk);
    #1;
    {xlate_req, xlate_addr} = {1'b1, a};
    @(posedge clk);
    #1;
    xlate_req = 1'b0;
    check({fwd_valid, fwd_miss, 8'h00},
          {e[9], ~e[9], 8'h00});
    if (e[9])
      check({1'b0, fwd_port, fwd_is_bridge, fwd_addr},
            {1'b0, e[8:0]});
  endtask
  task automatic dl(input logic p, input logic [6:0] a, input int w);
    bcc_u.deliver(p, a, w);
    @(posedge clk);
    #1;
    if (lock_req[p] && !mh[p])
      mb[p] = a;
    cmp_all();
  endtask
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==================
  // Main sequence
  initial
  begin
    logic [7:0] a, d;
    mb = '{7'h00, 7'h00};
    ma = '{7'h00, 7'h00};
    mp = '{8'h00, 8'h00};
    mh = '{1'b0, 1'b0};
    msel = 1'b0;
    void'($urandom(32'hd73e7ff1));
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    // Reset values on both ports, unmapped offset, zero never matches
    for (int p = 1; p >= 0; p--)
    begin
      wr(8'h1e, {7'h00, p[0]}, 1'b1);
      foreach (offs[i]) rd(offs[i]);
    end
    xl(7'h00);
    // Load on lock, then hold set by software blocks loading
    lock_req = 2'b01;
    dl(1'b0, 7'h2c, 0);
    dl(1'b1, 7'h44, 1);
    wr(8'h06, {7'h15, 1'b1}, 1'b1);
    dl(1'b0, 7'h33, 2);
    xl(7'h15);
    // Random mix of accesses, translations and deliveries
    repeat (300)
    begin
      a = offs[$urandom_range(4)];
      d = 8'($urandom);
      case ($urandom_range(4))
        0: wr(a, d, $urandom_range(9) != 0);
        1: rd(a);
        2: xl($urandom_range(1) ? d[6:0] : (d[0] ? mb[d[7]] : ma[d[7]]));
        3: dl(d[7], d[6:0], $urandom_range(3));
        default: lock_req = 2'($urandom);
      endcase
      cmp_all();
    end
    conclude();
  end
  // Watchdog
  initial
  begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
